// ---- shared/sdbcs_if.sv ----
// Pin bundle between memory controller and SDRAM command/state logic.
// Assumes both ends share core_clk; controller drives every pin here.
`timescale 1ns/1ps
interface sdbcs_if;
   logic                           clkEn;
   logic                           sel_n;
   logic                           rowStrobe_n;
   logic                           colStrobe_n;
   logic                           writeEn_n;
   logic [sdbcs_pkg::BANK_W-1:0]   bank;
   logic [sdbcs_pkg::ADDR_W-1:0]   addr;
   logic                           dataMask;

   modport ctrl (
      output clkEn,
      output sel_n,
      output rowStrobe_n,
      output colStrobe_n,
      output writeEn_n,
      output bank,
      output addr,
      output dataMask
   );
   modport mem (
      input  clkEn,
      input  sel_n,
      input  rowStrobe_n,
      input  colStrobe_n,
      input  writeEn_n,
      input  bank,
      input  addr,
      input  dataMask
   );
endinterface

// ---- shared/sdbcs_pkg.sv ----
// Shared constants and types for the SDRAM bank command/state block.
// Assumes a single 25 MHz core_clk shared by controller and device ends.
package sdbcs_pkg;
   // -------------------------------------------------------------
   // Timing (in ns) and derived cycle counts
   // -------------------------------------------------------------
   localparam int CLK_PERIOD_NS                = 40;
   localparam int PRECHARGE_PERIOD_NS          = 20;
   localparam int ROW_TO_COLUMN_DELAY_NS       = 20;
   localparam int WRITE_RECOVERY_TIME_NS       = 15;
   localparam int SELF_REFRESH_EXIT_TIME_NS    = 75;
   localparam int REFRESH_CYCLE_NS             = 66;
   localparam int MODE_ACCESS_NS               = 80;
   localparam int PRECHARGE_PERIOD_CYC    = (PRECHARGE_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int ROW_TO_COLUMN_DELAY_CYC = (ROW_TO_COLUMN_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int WRITE_RECOVERY_CYC      = (WRITE_RECOVERY_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;
   localparam int SELF_REFRESH_EXIT_CYC   = (SELF_REFRESH_EXIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int REFRESH_CYC             = (REFRESH_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int MODE_ACCESS_CYC         = (MODE_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CAS_LATENCY             = 2;
   localparam int BURST_LENGTH            = 4;
   localparam int NOP_MIN_IN_EXIT         = 2;
   localparam int DQM_LEAD_CYC            = 2;

   // -------------------------------------------------------------
   // Widths and field positions
   // -------------------------------------------------------------
   localparam int NUM_BANKS        = 4;
   localparam int BANK_W           = 2;
   localparam int ADDR_W           = 13;
   localparam int DATA_W           = 16;
   localparam int CNT_W            = 4;
   localparam int AUTO_PRE_BIT     = 10;
   localparam int WRITE_BURST_MODE_BIT = 9;

   // Command code {sel_n, rowStrobe_n, colStrobe_n, writeEn_n}
   typedef enum logic [3:0] {
      SDBCS_CMD_NOP   = 4'h7,
      SDBCS_CMD_ACT   = 4'h3,
      SDBCS_CMD_READ  = 4'h5,
      SDBCS_CMD_WRITE = 4'h4,
      SDBCS_CMD_PRE   = 4'h2,
      SDBCS_CMD_REF   = 4'h1,
      SDBCS_CMD_LMR   = 4'h0,
      SDBCS_CMD_BST   = 4'h6
   } sdbcs_cmd_t;

   // Per-bank state
   typedef enum logic [2:0] {
      SDBCS_B_IDLE  = 3'b000,
      SDBCS_B_ACTG  = 3'b001,
      SDBCS_B_ACT   = 3'b010,
      SDBCS_B_RD    = 3'b011,
      SDBCS_B_WR    = 3'b100,
      SDBCS_B_RDA   = 3'b101,
      SDBCS_B_WRA   = 3'b110,
      SDBCS_B_PRE   = 3'b111
   } sdbcs_bank_t;

   // Whole-device power state
   typedef enum logic [2:0] {
      SDBCS_P_RUN   = 3'b000,
      SDBCS_P_PDN   = 3'b001,
      SDBCS_P_SREF  = 3'b010,
      SDBCS_P_SUSP  = 3'b011,
      SDBCS_P_XSR   = 3'b100,
      SDBCS_P_BUSY  = 3'b101
   } sdbcs_pwr_t;
endpackage

// ---- src/sdbcs_ctrl.sv ----
// Controller end: turns one-shot user requests into SDRAM pin activity.
// Assumes the user waits for reqReady before the next request.
`timescale 1ns/1ps
module sdbcs_ctrl (
   input  wire logic                          core_clk,
   input  wire logic                          nrst,
   sdbcs_if.ctrl                              pins,
   input  wire logic                          reqValid,
   input  wire logic [3:0]                    reqCmd,
   input  wire logic [sdbcs_pkg::BANK_W-1:0]  reqBank,
   input  wire logic [sdbcs_pkg::ADDR_W-1:0]  reqAddr,
   input  wire logic                          reqClkEn,
   input  wire logic                          reqMaskLead,
   output      logic                          reqReady
);
   // ----------------------------------------------------------------
   // Request sequencing
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      SDBCS_C_IDLE = 2'b00,
      SDBCS_C_MASK = 2'b01,
      SDBCS_C_XSR  = 2'b10
   } sdbcs_cst_t;
   sdbcs_cst_t                    cst;
   logic [sdbcs_pkg::CNT_W-1:0]   cnt;
   logic [3:0]                    heldCmd;
   logic [sdbcs_pkg::BANK_W-1:0]  heldBank;
   logic [sdbcs_pkg::ADDR_W-1:0]  heldAddr;
   logic                          prevClkEn;

   assign reqReady = (cst == SDBCS_C_IDLE);

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         cst              <= SDBCS_C_IDLE;
         cnt              <= '0;
         heldCmd          <= 4'h7;
         heldBank         <= '0;
         heldAddr         <= '0;
         prevClkEn        <= 1'b1;
         pins.clkEn       <= 1'b1;
         pins.sel_n       <= 1'b1;
         pins.rowStrobe_n <= 1'b1;
         pins.colStrobe_n <= 1'b1;
         pins.writeEn_n   <= 1'b1;
         pins.bank        <= '0;
         pins.addr        <= '0;
         pins.dataMask    <= 1'b0;
      end else begin
         prevClkEn <= pins.clkEn;
         {pins.sel_n, pins.rowStrobe_n, pins.colStrobe_n, pins.writeEn_n} <= 4'h7;
         unique case (cst)
            SDBCS_C_IDLE: begin
               pins.dataMask <= 1'b0;
               if (reqValid) begin
                  pins.clkEn <= reqClkEn;
                  if (reqMaskLead && reqCmd == sdbcs_pkg::SDBCS_CMD_WRITE) begin
                     pins.dataMask <= 1'b1; // RL5
                     heldCmd  <= reqCmd;
                     heldBank <= reqBank;
                     heldAddr <= reqAddr;
                     cnt      <= sdbcs_pkg::CNT_W'(sdbcs_pkg::DQM_LEAD_CYC);
                     cst      <= SDBCS_C_MASK;
                  end else begin
                     {pins.sel_n, pins.rowStrobe_n, pins.colStrobe_n, pins.writeEn_n} <= reqCmd;
                     pins.bank <= reqBank;
                     pins.addr <= reqAddr;
                     if (!prevClkEn && reqClkEn && !pins.clkEn) begin
                        cnt <= sdbcs_pkg::CNT_W'(sdbcs_pkg::SELF_REFRESH_EXIT_CYC); // RL11
                        cst <= SDBCS_C_XSR;
                     end
                  end
               end
            end
            SDBCS_C_MASK: begin
               if (cnt <= 1) begin
                  {pins.sel_n, pins.rowStrobe_n, pins.colStrobe_n, pins.writeEn_n} <= heldCmd;
                  pins.bank <= heldBank;
                  pins.addr <= heldAddr;
                  cst       <= SDBCS_C_IDLE;
               end else begin
                  cnt <= cnt - 1'b1;
               end
            end
            SDBCS_C_XSR: begin
               // Only NOPs while the exit time runs
               if (cnt <= 1) begin
                  cst <= SDBCS_C_IDLE;
               end else begin
                  cnt <= cnt - 1'b1;
               end
            end
            default: cst <= SDBCS_C_IDLE;
         endcase
      end
   end
endmodule

// ---- src/sdbcs_device.sv ----
// SDRAM device end: command decode, per-bank state, clock-enable table.
// Assumes pins are synchronous to core_clk; nrst stands in for power-up.
`timescale 1ns/1ps
// Contract
// RL1: Write-burst bit set gives single-column writes
// RL2: Accept other-bank access during auto precharge
// RL3: Read interrupts auto-precharge read CL later; the bank goes to precharge at the edge that registers the read instead
// RL4: Write interrupts auto-precharge read immediately
// RL5: Controller masks data two clocks before write
// RL6: Read ends auto-precharge write, then recovery
// RL7: Write ends auto-precharge write, then recovery
// RL8: Clock enable low twice holds low-power state
// RL9: Clock enable fall selects power-down/refresh/suspend
// RL10: Power-down exit gives idle next edge
// RL11: Controller waits exit time, two NOPs
// RL12: Suspend exit accepts command next edge
// RL13: Inhibit and NOP continue current operation
// RL14: Idle bank accepts activate/refresh/mode/precharge
// RL15: Active bank accepts read/write/precharge
// RL16: Read state accepts read/write/precharge/terminate
// RL17: Write state accepts read/write/precharge/terminate
// RL18: Idle only after precharge period elapsed
// RL19: Row active only after row-to-column delay
// RL20: Read/write state until burst ends
// RL21: Controller sends nothing to busy bank; sdbcs_ctrl forwards every request, device flags it on cmdIllegal
// RL22: Precharging/activating banks advance when timed
module sdbcs_device (
   input  wire logic                             core_clk,
   input  wire logic                             nrst,
   sdbcs_if.mem                                  pins,
   output      logic [3*sdbcs_pkg::NUM_BANKS-1:0] bankState,
   output      logic [2:0]                       pwrState,
   output      logic                             writeSingle,
   output      logic                             cmdAccepted,
   output      logic                             cmdIllegal
);
   // ----------------------------------------------------------------
   // Command decode and clock-enable history
   // ----------------------------------------------------------------
   logic                                 clkEnPrev;
   sdbcs_pkg::sdbcs_pwr_t                pwr;
   logic [sdbcs_pkg::CNT_W-1:0]          pwrCnt;
   logic                                 burstOne;
   logic [sdbcs_pkg::BANK_W-1:0]         lastBank;
   logic [3:0]                           cmdCode;
   logic                                 live;
   logic                                 isRead;
   logic                                 isWrite;
   logic                                 allIdle;
   logic                                 anyBurst;
   logic [sdbcs_pkg::NUM_BANKS-1:0]      idleVec;
   logic [sdbcs_pkg::NUM_BANKS-1:0]      burstVec;
   logic [sdbcs_pkg::NUM_BANKS-1:0]      okVec;
   logic [sdbcs_pkg::NUM_BANKS-1:0]      hitVec;

   assign cmdCode = pins.sel_n ? 4'h7 : {1'b0, pins.rowStrobe_n, pins.colStrobe_n, pins.writeEn_n}; // RL13
   // Commands act only with clock enable high at both edges
   assign live    = clkEnPrev && pins.clkEn && (pwr == sdbcs_pkg::SDBCS_P_RUN); // RL12
   assign isRead  = live && (cmdCode == sdbcs_pkg::SDBCS_CMD_READ);
   assign isWrite = live && (cmdCode == sdbcs_pkg::SDBCS_CMD_WRITE);
   assign allIdle = &idleVec;
   assign anyBurst = |burstVec;

   // Clock enable at previous edge
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         clkEnPrev <= 1'b1;
      end else begin
         clkEnPrev <= pins.clkEn; // RL8
      end
   end

   // Mode register write burst bit
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         burstOne <= 1'b0;
      end else if (live && cmdCode == sdbcs_pkg::SDBCS_CMD_LMR && allIdle) begin
         burstOne <= pins.addr[sdbcs_pkg::WRITE_BURST_MODE_BIT]; // RL1
      end
   end

   // Most recent burst bank
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         lastBank <= '0;
      end else if (live && (isRead || isWrite)) begin
         lastBank <= pins.bank;
      end
   end

   // ----------------------------------------------------------------
   // Power state: clock-enable transitions, refresh and mode-register busy time
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         pwr    <= sdbcs_pkg::SDBCS_P_RUN;
         pwrCnt <= '0;
      end else begin
         unique case (pwr)
            sdbcs_pkg::SDBCS_P_RUN: begin
               if (clkEnPrev && !pins.clkEn) begin // RL9
                  if (allIdle && cmdCode == sdbcs_pkg::SDBCS_CMD_REF) begin
                     pwr <= sdbcs_pkg::SDBCS_P_SREF;
                  end else if (allIdle && cmdCode == sdbcs_pkg::SDBCS_CMD_NOP) begin
                     pwr <= sdbcs_pkg::SDBCS_P_PDN;
                  end else if (anyBurst) begin
                     pwr <= sdbcs_pkg::SDBCS_P_SUSP;
                  end else begin
                     pwr <= sdbcs_pkg::SDBCS_P_PDN;
                  end
               end else if (live && allIdle && cmdCode == sdbcs_pkg::SDBCS_CMD_REF) begin
                  pwr    <= sdbcs_pkg::SDBCS_P_BUSY;
                  pwrCnt <= sdbcs_pkg::CNT_W'(sdbcs_pkg::REFRESH_CYC);
               end else if (live && allIdle && cmdCode == sdbcs_pkg::SDBCS_CMD_LMR) begin
                  pwr    <= sdbcs_pkg::SDBCS_P_BUSY;
                  pwrCnt <= sdbcs_pkg::CNT_W'(sdbcs_pkg::MODE_ACCESS_CYC);
               end
            end
            sdbcs_pkg::SDBCS_P_PDN: begin
               if (pins.clkEn && cmdCode == sdbcs_pkg::SDBCS_CMD_NOP) begin
                  pwr <= sdbcs_pkg::SDBCS_P_RUN; // RL10
               end
            end
            sdbcs_pkg::SDBCS_P_SREF: begin
               if (pins.clkEn && cmdCode == sdbcs_pkg::SDBCS_CMD_NOP) begin
                  pwr    <= sdbcs_pkg::SDBCS_P_XSR; // RL11
                  pwrCnt <= sdbcs_pkg::CNT_W'(sdbcs_pkg::SELF_REFRESH_EXIT_CYC);
               end
            end
            sdbcs_pkg::SDBCS_P_SUSP: begin
               if (pins.clkEn) begin
                  pwr <= sdbcs_pkg::SDBCS_P_RUN; // RL12
               end
            end
            sdbcs_pkg::SDBCS_P_XSR, sdbcs_pkg::SDBCS_P_BUSY: begin
               if (pwrCnt <= 1) begin
                  pwr    <= sdbcs_pkg::SDBCS_P_RUN;
                  pwrCnt <= '0;
               end else begin
                  pwrCnt <= pwrCnt - 1'b1;
               end
            end
            default: begin
               pwr <= sdbcs_pkg::SDBCS_P_RUN;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Per-bank state machines
   // ----------------------------------------------------------------
   generate
      for (genvar b = 0; b < sdbcs_pkg::NUM_BANKS; b++) begin : gBank
         sdbcs_pkg::sdbcs_bank_t        st;
         logic [sdbcs_pkg::CNT_W-1:0]   cnt;
         logic                          wrPend;
         logic                          mine;
         logic                          allPre;
         assign mine   = (pins.bank == sdbcs_pkg::BANK_W'(b));
         assign allPre = pins.addr[sdbcs_pkg::AUTO_PRE_BIT];
         assign idleVec[b]  = (st == sdbcs_pkg::SDBCS_B_IDLE);
         assign burstVec[b] = (st == sdbcs_pkg::SDBCS_B_RD) || (st == sdbcs_pkg::SDBCS_B_WR) ||
                              (st == sdbcs_pkg::SDBCS_B_RDA) || (st == sdbcs_pkg::SDBCS_B_WRA);
         assign bankState[3*b +: 3] = st;
         assign hitVec[b] = live && mine && cmdCode != sdbcs_pkg::SDBCS_CMD_NOP;

         // Bank legality for a command addressed to it
         always_comb begin
            okVec[b] = 1'b1;
            if (hitVec[b]) begin
               unique case (st)
                  sdbcs_pkg::SDBCS_B_IDLE: okVec[b] = (cmdCode == sdbcs_pkg::SDBCS_CMD_ACT) ||
                                                      (cmdCode == sdbcs_pkg::SDBCS_CMD_PRE) ||
                                                      (cmdCode == sdbcs_pkg::SDBCS_CMD_REF) ||
                                                      (cmdCode == sdbcs_pkg::SDBCS_CMD_LMR); // RL14
                  sdbcs_pkg::SDBCS_B_ACTG,
                  sdbcs_pkg::SDBCS_B_PRE:  okVec[b] = 1'b0; // RL21
                  sdbcs_pkg::SDBCS_B_ACT:  okVec[b] = isRead || isWrite ||
                                                      (cmdCode == sdbcs_pkg::SDBCS_CMD_PRE); // RL15
                  default:                 okVec[b] = isRead || isWrite || (cmdCode == sdbcs_pkg::SDBCS_CMD_PRE) ||
                                                      (cmdCode == sdbcs_pkg::SDBCS_CMD_BST);
               endcase
            end
         end

         always_ff @(posedge core_clk or negedge nrst) begin
            if (!nrst) begin
               st     <= sdbcs_pkg::SDBCS_B_IDLE;
               cnt    <= '0;
               wrPend <= 1'b0;
            end else if (pwr == sdbcs_pkg::SDBCS_P_RUN && !(clkEnPrev && !pins.clkEn && anyBurst)) begin
               // Timers run only in the run power state, and not on a suspend-entry edge
               if (live && cmdCode == sdbcs_pkg::SDBCS_CMD_PRE && (mine || allPre) &&
                   st != sdbcs_pkg::SDBCS_B_ACTG && st != sdbcs_pkg::SDBCS_B_PRE) begin
                  st  <= sdbcs_pkg::SDBCS_B_PRE; // RL16 RL17
                  cnt <= sdbcs_pkg::CNT_W'(sdbcs_pkg::PRECHARGE_PERIOD_CYC);
               end else if (live && mine && (isRead || isWrite) && st != sdbcs_pkg::SDBCS_B_IDLE &&
                            st != sdbcs_pkg::SDBCS_B_ACTG && st != sdbcs_pkg::SDBCS_B_PRE) begin
                  st  <= pins.addr[sdbcs_pkg::AUTO_PRE_BIT] ?
                         (isRead ? sdbcs_pkg::SDBCS_B_RDA : sdbcs_pkg::SDBCS_B_WRA) :
                         (isRead ? sdbcs_pkg::SDBCS_B_RD  : sdbcs_pkg::SDBCS_B_WR); // RL15 RL16 RL17
                  cnt <= (isWrite && burstOne) ? sdbcs_pkg::CNT_W'(1) :
                         sdbcs_pkg::CNT_W'(sdbcs_pkg::BURST_LENGTH); // RL1
                  wrPend <= 1'b0;
               end else if (live && mine && cmdCode == sdbcs_pkg::SDBCS_CMD_ACT &&
                            st == sdbcs_pkg::SDBCS_B_IDLE) begin
                  st  <= sdbcs_pkg::SDBCS_B_ACTG;
                  cnt <= sdbcs_pkg::CNT_W'(sdbcs_pkg::ROW_TO_COLUMN_DELAY_CYC);
               end else if (live && cmdCode == sdbcs_pkg::SDBCS_CMD_BST && lastBank == sdbcs_pkg::BANK_W'(b) &&
                            (st == sdbcs_pkg::SDBCS_B_RD || st == sdbcs_pkg::SDBCS_B_WR)) begin
                  st <= sdbcs_pkg::SDBCS_B_ACT; // RL16 RL17 RL20
               end else if (st == sdbcs_pkg::SDBCS_B_RDA && (isRead || isWrite) && !mine) begin
                  st  <= sdbcs_pkg::SDBCS_B_PRE; // RL2 RL3 RL4
                  cnt <= sdbcs_pkg::CNT_W'(sdbcs_pkg::PRECHARGE_PERIOD_CYC);
               end else if (st == sdbcs_pkg::SDBCS_B_WRA && (isRead || isWrite) && !mine && !wrPend) begin
                  wrPend <= 1'b1; // RL2 RL6 RL7
                  cnt    <= sdbcs_pkg::CNT_W'(sdbcs_pkg::WRITE_RECOVERY_CYC);
               end else if (cnt > 1) begin
                  cnt <= cnt - 1'b1;
               end else if (cnt == 1) begin
                  cnt <= '0;
                  unique case (st)
                     sdbcs_pkg::SDBCS_B_PRE:  st <= sdbcs_pkg::SDBCS_B_IDLE; // RL18 RL22
                     sdbcs_pkg::SDBCS_B_ACTG: st <= sdbcs_pkg::SDBCS_B_ACT;  // RL19 RL22
                     sdbcs_pkg::SDBCS_B_RD,
                     sdbcs_pkg::SDBCS_B_WR:   st <= sdbcs_pkg::SDBCS_B_ACT;  // RL20
                     sdbcs_pkg::SDBCS_B_RDA,
                     sdbcs_pkg::SDBCS_B_WRA: begin
                        st     <= sdbcs_pkg::SDBCS_B_PRE;
                        cnt    <= sdbcs_pkg::CNT_W'(sdbcs_pkg::PRECHARGE_PERIOD_CYC);
                        wrPend <= 1'b0;
                     end
                     default:                 st <= st;
                  endcase
               end
            end
         end
      end
   endgenerate

   // ----------------------------------------------------------------
   // Status outputs
   // ----------------------------------------------------------------
   assign pwrState    = pwr;
   assign writeSingle = burstOne;
   assign cmdAccepted = live && cmdCode != sdbcs_pkg::SDBCS_CMD_NOP && (&okVec);
   assign cmdIllegal  = live && cmdCode != sdbcs_pkg::SDBCS_CMD_NOP && !(&okVec);
endmodule

// ---- test/sdbcs_props.sv ----
// Checker on the controller pins and the device state outputs.
// Assumes instantiation beside the interface in the bench top.
`timescale 1ns/1ps
module sdbcs_props (
   input wire logic        core_clk,
   input wire logic        nrst,
   input wire logic        clkEn,
   input wire logic        sel_n,
   input wire logic        rowStrobe_n,
   input wire logic        colStrobe_n,
   input wire logic        writeEn_n,
   input wire logic [1:0]  bank,
   input wire logic [12:0] addr,
   input wire logic [11:0] bankState,
   input wire logic [2:0]  pwrState,
   input wire logic        writeSingle,
   input wire logic        cmdIllegal
);
   logic       prevCe;
   logic [3:0] cmd;
   logic       live;
   logic [2:0] b0;
   logic       idle;
   default clocking @(posedge core_clk); endclocking
   default disable iff (!nrst);
   // Clock-enable level at the previous edge
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) prevCe <= 1'b1;
      else prevCe <= clkEn;
   end
   // Decoded pin command and live-edge flag
   assign cmd  = {sel_n, rowStrobe_n, colStrobe_n, writeEn_n};
   assign live = clkEn & prevCe & (pwrState == 3'h0);
   assign b0   = bankState[2:0];
   assign idle = (bankState == 12'h000);
   AST_ACT_START: assert property (live && cmd == 4'h3 && bank == 2'h0 && b0 == 3'h0 |=> b0 == 3'h1)
      else $error("activate ignored");
   AST_ACT_DONE: assert property (b0 == 3'h1 |-> ##[1:4] b0 == 3'h2)
      else $error("row never active");
   AST_PRE_DONE: assert property (b0 == 3'h7 |-> ##[1:4] b0 == 3'h0)
      else $error("precharge never idle");
   AST_WBM: assert property (live && cmd == 4'h0 |=> writeSingle == $past(addr[9]))
      else $error("write burst bit wrong");
   AST_HOLD_LOW: assert property (!clkEn && !prevCe && pwrState inside {3'h1, 3'h2, 3'h3} |=> $stable(pwrState))
      else $error("low power state lost");
   AST_PDN_ENTRY: assert property (prevCe && !clkEn && pwrState == 3'h0 && idle && cmd == 4'h7 |=> pwrState == 3'h1)
      else $error("no power-down entry");
   AST_SREF_ENTRY: assert property (prevCe && !clkEn && pwrState == 3'h0 && idle && cmd == 4'h1 |=> pwrState == 3'h2)
      else $error("no self refresh entry");
   AST_PDN_EXIT: assert property (pwrState == 3'h1 && !prevCe && clkEn && cmd == 4'h7 |=> pwrState == 3'h0)
      else $error("no power-down exit");
   AST_CONC_AP: assert property (live && cmd == 4'h5 && bank == 2'h1 && b0 == 3'h5 |=> b0 == 3'h7)
      else $error("no concurrent precharge");
   AST_NO_ILLEGAL: assert property (!cmdIllegal)
      else $error("command to busy bank");
endmodule

// ---- test/sdram_bank_cmd_state_tb_top.sv ----
// Bench joining controller and device ends through the pin interface.
// Assumes the user side of the controller is the only stimulus.
`timescale 1ns/1ps
module sdram_bank_cmd_state_tb_top;
   logic        core_clk = 1'b0;
   logic        nrst = 1'b0;
   logic        reqValid = 1'b0;
   logic [3:0]  reqCmd = 4'h7;
   logic [1:0]  reqBank = 2'h0;
   logic [12:0] reqAddr = 13'h0000;
   logic        reqClkEn = 1'b1;
   logic        reqMaskLead = 1'b0;
   logic        reqReady;
   logic [11:0] bankState;
   logic [2:0]  pwrState;
   logic        writeSingle;
   logic        cmdIllegal;
   int          n_fail = 0;
   int          tests_run = 0;
   int          cyc = 0;
   sdbcs_if pins ();
   sdbcs_ctrl i_sdbcs_ctrl (.core_clk(core_clk), .nrst(nrst), .pins(pins), .reqValid(reqValid), .reqCmd(reqCmd),
      .reqBank(reqBank), .reqAddr(reqAddr), .reqClkEn(reqClkEn), .reqMaskLead(reqMaskLead), .reqReady(reqReady));
   sdbcs_device i_sdbcs_device (.core_clk(core_clk), .nrst(nrst), .pins(pins), .bankState(bankState),
      .pwrState(pwrState), .writeSingle(writeSingle), .cmdAccepted(), .cmdIllegal(cmdIllegal));
   sdbcs_props i_sdbcs_props (.core_clk(core_clk), .nrst(nrst), .clkEn(pins.clkEn), .sel_n(pins.sel_n),
      .rowStrobe_n(pins.rowStrobe_n), .colStrobe_n(pins.colStrobe_n), .writeEn_n(pins.writeEn_n), .bank(pins.bank),
      .addr(pins.addr), .bankState(bankState), .pwrState(pwrState), .writeSingle(writeSingle),
      .cmdIllegal(cmdIllegal));
   // Clock and hang guard
   always #20 core_clk = ~core_clk;
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 5000) begin
         n_fail++;
         tally_and_finish();
      end
   end
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic check(input string what, input logic [11:0] seen, input logic [11:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // One request through the controller, taken on reqReady
   task automatic issue(input logic [3:0] c, input logic [1:0] b, input logic [12:0] a, input logic ce, input logic ml);
      int k;
      k = 0;
      while (reqReady !== 1'b1 && k < 50) begin
         @(negedge core_clk);
         k++;
      end
      {reqCmd, reqBank, reqAddr, reqClkEn, reqMaskLead} = {c, b, a, ce, ml};
      reqValid = 1'b1;
      @(negedge core_clk);
      reqValid = 1'b0;
      @(negedge core_clk);
   endtask
   // Bounded wait for a bank state (sel 0..3) or the power state (sel 4)
   task automatic expect_st(input string what, input int sel, input logic [2:0] st, input int lim);
      int k;
      k = 0;
      while (((sel == 4) ? pwrState : bankState[3*sel +: 3]) !== st && k < lim) begin
         @(negedge core_clk);
         k++;
      end
      check(what, {9'h000, (sel == 4) ? pwrState : bankState[3*sel +: 3]}, {9'h000, st});
   endtask
   task automatic t_mode();
      issue(4'h0, 2'h0, 13'h0200, 1'b1, 1'b0);
      expect_st("pwr", 4, 3'h0, 12);
      check("wsingle", {11'h000, writeSingle}, 12'h001);
      issue(4'h0, 2'h0, 13'h0000, 1'b1, 1'b0);
      expect_st("pwr", 4, 3'h0, 12);
      check("wsingle", {11'h000, writeSingle}, 12'h000);
   endtask
   task automatic t_row();
      issue(4'h3, 2'h0, 13'h0000, 1'b1, 1'b0);
      expect_st("b0 act", 0, 3'h2, 8);
      issue(4'h5, 2'h0, 13'h0000, 1'b1, 1'b0);
      expect_st("b0 rd", 0, 3'h3, 4);
      issue(4'h2, 2'h0, 13'h0000, 1'b1, 1'b0);
      expect_st("b0 pre", 0, 3'h0, 8);
   endtask
   task automatic t_conc();
      issue(4'h3, 2'h0, 13'h0000, 1'b1, 1'b0);
      issue(4'h3, 2'h1, 13'h0000, 1'b1, 1'b0);
      expect_st("b1 act", 1, 3'h2, 8);
      issue(4'h5, 2'h0, 13'h0400, 1'b1, 1'b0);
      expect_st("b0 rda", 0, 3'h5, 4);
      issue(4'h5, 2'h1, 13'h0000, 1'b1, 1'b0);
      expect_st("b0 cut", 0, 3'h7, 3);
      expect_st("b0 idle", 0, 3'h0, 8);
      issue(4'h3, 2'h0, 13'h0000, 1'b1, 1'b0);
      expect_st("b1 act", 1, 3'h2, 8);
      issue(4'h5, 2'h0, 13'h0400, 1'b1, 1'b0);
      issue(4'h4, 2'h1, 13'h0000, 1'b1, 1'b1);
      @(negedge core_clk);
      check("mask", {11'h000, pins.dataMask}, 12'h001);
      expect_st("b0 cut", 0, 3'h7, 6);
      expect_st("b0 idle", 0, 3'h0, 8);
      issue(4'h3, 2'h0, 13'h0000, 1'b1, 1'b0);
      expect_st("b1 act", 1, 3'h2, 8);
      issue(4'h4, 2'h0, 13'h0400, 1'b1, 1'b0);
      expect_st("b0 wra", 0, 3'h6, 4);
      issue(4'h4, 2'h1, 13'h0000, 1'b1, 1'b0);
      expect_st("b0 rec", 0, 3'h7, 8);
      issue(4'h2, 2'h0, 13'h0400, 1'b1, 1'b0);
      expect_st("all idle", 0, 3'h0, 8);
      expect_st("b1 idle", 1, 3'h0, 8);
   endtask
   task automatic t_power();
      issue(4'hF, 2'h0, 13'h0000, 1'b0, 1'b0);
      expect_st("pdn", 4, 3'h1, 4);
      repeat (5) @(negedge core_clk);
      check("pdn hold", {9'h000, pwrState}, 12'h001);
      issue(4'h7, 2'h0, 13'h0000, 1'b1, 1'b0);
      expect_st("pdn exit", 4, 3'h0, 4);
      issue(4'h1, 2'h0, 13'h0000, 1'b0, 1'b0);
      expect_st("sref", 4, 3'h2, 4);
      issue(4'h7, 2'h0, 13'h0000, 1'b1, 1'b0);
      expect_st("sref exit", 4, 3'h0, 12);
      issue(4'h3, 2'h0, 13'h0000, 1'b1, 1'b0);
      issue(4'h5, 2'h0, 13'h0000, 1'b1, 1'b0);
      issue(4'h7, 2'h0, 13'h0000, 1'b0, 1'b0);
      expect_st("susp", 4, 3'h3, 4);
      issue(4'h7, 2'h0, 13'h0000, 1'b1, 1'b0);
      expect_st("susp exit", 4, 3'h0, 4);
      expect_st("b0 resume", 0, 3'h2, 8);
   endtask
   initial begin
      repeat (20) @(negedge core_clk);
      nrst = 1'b1;
      t_mode();
      t_row();
      t_conc();
      t_power();
      tally_and_finish();
   end
endmodule
